// >>> bench/secm_remote_tx.sv
// Remote asynchronous transmitter model that drives the receive pin
`timescale 1ns/1ps
module secm_remote_tx (
  input  wire logic pclk,
  output logic      line
);
  // Line idles high between frames, as an asynchronous link does
  initial line = 1'b1;

  // ==========================================================
  // Frame: start bit, eight data bits LSB first, stop bit, two idle bits
  task automatic send(input logic [7:0] data, input int cyc);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++)
    begin
      line <= frame[i];
      repeat (cyc) @(posedge pclk);
    end
    repeat (2 * cyc) @(posedge pclk);
  endtask

  // Static level, used for break and glitch cases
  task automatic level(input logic v);
    @(posedge pclk);
    line <= v;
  endtask
endmodule // secm_remote_tx

// >>> bench/secm_top_tb.sv
// Self-checking testbench for the serial extended mode control block
`timescale 1ns/1ps
module secm_top_tb;
  import secm_pkg::*;
  localparam int          DIV   = 4;
  localparam int          LIMIT = 20000;
  localparam logic [31:0] A_EXT = {SECM_EXT_MODE_INDEX[29:0], 2'b00};
  localparam logic [31:0] A_CTL = {SECM_CTRL_INDEX[29:0], 2'b00};
  localparam logic [31:0] A_STA = {SECM_STATUS_INDEX[29:0], 2'b00};
  localparam logic [31:0] A_DAT = {SECM_DATA_INDEX[29:0], 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        ext_clk, tmr1, tmr2, rx_line, scl, sda;
  logic        base_tick, bit_tick, start_det, rx_int, scl_int, sda_int;
  int          fails, cmp_count, cyc, n_base, n_start, snap, gap, d, d2;
  int          n_low [3];
  int          acs_t [5] = '{0, 0, 1, 1, 1};
  logic [2:0]  sel_t [5] = '{3'h1, 3'h6, 3'h1, 3'h2, 3'h6};
  int          exp_t [5] = '{5, 0, 0, 0, 5};
  logic [7:0]  bytes [5] = '{8'h5a, 8'h81, 8'h00, 8'hff, 8'h3c};

  secm_top #(.INT_DIV(DIV)) i_secm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk), .timer1_compare_out(tmr1), .timer2_compare_out(tmr2), .receive_data_pin(rx_line),
    .i2c_clock_pin(scl), .i2c_data_pin(sda), .base_clk_tick(base_tick), .bit_tick(bit_tick),
    .start_detected(start_det), .rx_internal(rx_int), .scl_internal(scl_int), .sda_internal(sda_int));
  secm_remote_tx i_secm_remote_tx (.pclk(pclk), .line(rx_line));

  // ==========================================================
  // Clock, and cycle ceiling so a hang cannot run forever
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails = fails + 1;
      stop_test();
    end
  end

  // Outputs counted on the falling edge, where they are settled
  always @(negedge pclk)
  begin
    n_base <= n_base + base_tick;
    n_start <= n_start + start_det;
    n_low[0] <= n_low[0] + !rx_int;
    n_low[1] <= n_low[1] + !scl_int;
    n_low[2] <= n_low[2] + !sda_int;
    if (bit_tick)
    begin
      gap <= n_base + base_tick - snap;
      snap <= n_base + base_tick;
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Pulse the base clock pins given as {timer 2, timer 1, external}
  task automatic src(input logic [2:0] pat, input int n);
    repeat (n)
    begin
      {tmr2, tmr1, ext_clk} <= pat;
      wt(4);
      {tmr2, tmr1, ext_clk} <= 3'h0;
      wt(4);
    end
  endtask

  // One-cycle low glitch on pin 0 receive, 1 clock, 2 data
  task automatic glitch(input int p);
    if (p == 0)
    begin
      i_secm_remote_tx.level(1'b0);
      i_secm_remote_tx.level(1'b1);
    end
    else
    begin
      @(posedge pclk);
      scl <= (p != 1);
      sda <= (p != 2);
      @(posedge pclk);
      scl <= 1'b1;
      sda <= 1'b1;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, ext_clk, tmr1, tmr2} = '0;
    {paddr, pwdata, fails, cmp_count, cyc, n_base, n_start, snap, gap} = '0;
    n_low = '{0, 0, 0};
    scl = 1'b1;
    sda = 1'b1;
    presetn = 1'b0;
    wt(20);
    presetn <= 1'b1;
    // Register reset value and reserved bits
    apb(0, A_EXT, 0);
    check(rd, 0);
    apb(1, A_EXT, 32'hff);
    apb(0, A_EXT, 0);
    check(rd, 32'hb1);
    // Writes are ignored while transmit or receive is on
    for (int k = 0; k < 2; k++)
    begin
      apb(1, A_CTL, k ? 32'h10 : 32'h20);
      apb(1, A_EXT, 0);
      apb(0, A_EXT, 0);
      check(rd, 32'hb1);
    end
    apb(1, A_CTL, 0);
    apb(1, A_EXT, 0);
    apb(0, A_EXT, 0);
    check(rd, 0);
    // Another channel's register is not this instance's
    apb(0, A_EXT + 32'h200, 0);
    check({31'h0, err}, 1);
    check(rd, 0);
    // Base clock source: external input against AND of both timers
    apb(1, A_CTL, 32'h08);
    for (int k = 0; k < 5; k++)
    begin
      apb(1, A_EXT, acs_t[k]);
      d = n_base;
      src(sel_t[k], 5);
      wt(8);
      check(n_base - d, exp_t[k]);
    end
    // Internal clock selected: the source bit has no effect
    apb(1, A_CTL, 0);
    d = n_base;
    src(3'h7, 5); // Every source pulses, none of it may count
    check((n_base - d >= 9) && (n_base - d <= 11), 1);
    apb(1, A_EXT, 0);
    // Bit length 16 then 8 base cycles, byte received LSB first
    for (int k = 0; k < 2; k++)
    begin
      apb(1, A_EXT, k ? 32'h10 : 0);
      apb(1, A_CTL, 32'h20);
      i_secm_remote_tx.send(bytes[k], (k ? 8 : 16) * DIV);
      check(gap, k ? 8 : 16);
      apb(0, A_DAT, 0);
      check(rd, bytes[k]);
      apb(1, A_CTL, 0);
    end
    // Five frames into a four-word buffer: fills, holds one, drains
    apb(1, A_CTL, 32'h20);
    for (int k = 0; k < 5; k++)
      i_secm_remote_tx.send(bytes[k], 8 * DIV);
    apb(0, A_STA, 0);
    check(rd & 32'h18, 32'h18);
    for (int k = 0; k < 5; k++)
    begin
      apb(0, A_DAT, 0);
      check(rd, bytes[k]);
    end
    apb(0, A_STA, 0);
    check(rd & 32'h18, 0);
    // Edge detection: a line already low in a break starts nothing
    apb(1, A_CTL, 0);
    apb(1, A_EXT, 32'h80);
    i_secm_remote_tx.level(1'b0);
    d = n_start;
    apb(1, A_CTL, 32'h20);
    wt(60);
    check(n_start - d, 0);
    i_secm_remote_tx.level(1'b1);
    wt(8);
    d = n_start;
    i_secm_remote_tx.level(1'b0);
    wt(60);
    check(n_start - d, 1);
    // Level detection: the same held-low line starts a frame
    apb(1, A_CTL, 0);
    apb(1, A_EXT, 0);
    d = n_start;
    apb(1, A_CTL, 32'h20);
    wt(60);
    check(n_start - d, 1);
    i_secm_remote_tx.level(1'b1);
    apb(1, A_CTL, 0);
    wt(800);
    apb(1, A_STA, 32'h3f);
    // Noise filter per mode and pin: glitch passes raw, is removed when on
    for (int p = 0; p < 3; p++)
      for (int f = 0; f < 2; f++)
      begin
        apb(1, A_CTL, p ? 32'h01 : 0);
        apb(1, A_EXT, f ? 32'h20 : 0);
        d = n_low[p];
        glitch(p);
        wt(6);
        check(n_low[p] - d, f ? 0 : 1);
      end
    // Filter on in simple I2C mode: a real low on both lines still gets through
    d = n_low[1];
    d2 = n_low[2];
    @(posedge pclk);
    scl <= 1'b0;
    sda <= 1'b0;
    wt(4);
    scl <= 1'b1;
    sda <= 1'b1;
    wt(6);
    check(n_low[1] - d, 4);
    check(n_low[2] - d2, 4);
    stop_test();
  end
endmodule // secm_top_tb

// >>> common/secm_pkg.sv
// Shared constants for the serial extended mode control block
package secm_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [31:0] SECM_EXT_MODE_INDEX = 32'h0008a027;
  localparam logic [31:0] SECM_CTRL_INDEX     = 32'h0008a030;
  localparam logic [31:0] SECM_STATUS_INDEX   = 32'h0008a031;
  localparam logic [31:0] SECM_DATA_INDEX     = 32'h0008a032;

  // ==========================================================
  // Extended mode register fields
  localparam int          SECM_ACS_BIT    = 0;
  localparam int          SECM_ASYNC_BASE_CYCLES_SEL_BIT   = 4;
  localparam int          SECM_NOISE_FILTER_ENABLE_BIT   = 5;
  localparam int          SECM_SDES_BIT   = 7;
  localparam logic [7:0]  SECM_EXT_WMASK  = 8'hb1;
  localparam logic [7:0]  SECM_EXT_RESET  = 8'h00;

  // ==========================================================
  // Own control register fields
  localparam int          SECM_MODE_LSB   = 0;
  localparam int          SECM_CKE_LSB    = 2;
  localparam int          SECM_TE_BIT     = 4;
  localparam int          SECM_RE_BIT     = 5;
  localparam logic [5:0]  SECM_CTRL_RESET = 6'h00;
  localparam logic [1:0]  SECM_MODE_ASYNC = 2'h0;
  localparam logic [1:0]  SECM_MODE_I2C   = 2'h1;

  // ==========================================================
  // Status register fields
  localparam int          SECM_ST_RX_BIT    = 0;
  localparam int          SECM_ST_SCL_BIT   = 1;
  localparam int          SECM_ST_SDA_BIT   = 2;
  localparam int          SECM_ST_AVAIL_BIT = 3;
  localparam int          SECM_ST_FULL_BIT  = 4;
  localparam int          SECM_ST_FERR_BIT  = 5;

  // ==========================================================
  // Timing
  localparam logic [4:0]  SECM_CYCLES_16  = 5'h10;
  localparam logic [4:0]  SECM_CYCLES_8   = 5'h08;
  localparam logic [2:0]  SECM_LAST_BIT   = 3'h7;

  // Receive state machine, one-hot
  typedef enum logic [4:0] {
    SECM_RX_IDLE  = 5'b00001,
    SECM_RX_START = 5'b00010,
    SECM_RX_DATA  = 5'b00100,
    SECM_RX_STOP  = 5'b01000,
    SECM_RX_HOLD  = 5'b10000
  } secm_rx_e;

endpackage

// >>> hdl/secm_top.sv
// Serial extended mode control: clock source, bit length, noise filter, start detection
`timescale 1ns/1ps
// What this block does
// - In asynchronous mode a bit lasts 16 base clock cycles when the base cycles bit is 0 and 8 when it is 1.
// - The clock source bit picks the external clock input when 0 and the AND of both timer compare outputs when 1.
// - The clock source bit matters only in asynchronous mode with the clock enable field at 10b or 11b.
// - Timer channel 1 and 2 compare outputs can serve as base clock for every channel instance.
// - In asynchronous mode the noise filter bit filters the receive input, and clearing it leaves it raw.
// - In simple I2C mode the noise filter bit filters both the clock and data inputs.
// - With the filter off the pin levels reach the internal logic unfiltered.
// - In asynchronous mode a start bit is a low level when the start detect bit is 0 and a falling edge when 1.
// - Writes to the extended mode fields land only while transmit and receive enable are both 0.
// - Reserved bits of the extended mode register read as 0.

// ==========================================================
// Received byte FIFO
module secm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  // Refused at elaboration: the wrap bit of the pointers needs a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("secm_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Extra pointer bit separates full from empty
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Pointer update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule // secm_fifo

// ==========================================================
// Top level
module secm_top #(
  parameter logic [31:0] EXT_INDEX   = secm_pkg::SECM_EXT_MODE_INDEX,
  parameter int          INT_DIV     = 4,
  parameter int          FIFO_DEPTH  = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clk_in,
  input  wire logic        timer1_compare_out,
  input  wire logic        timer2_compare_out,
  input  wire logic        receive_data_pin,
  input  wire logic        i2c_clock_pin,
  input  wire logic        i2c_data_pin,
  output logic             base_clk_tick,
  output logic             bit_tick,
  output logic             start_detected,
  output logic             rx_internal,
  output logic             scl_internal,
  output logic             sda_internal
);
  import secm_pkg::*;

  // Refused at elaboration: the rate divider counter is eight bits wide
  if (INT_DIV < 1 || INT_DIV > 255)
  begin : g_bad_div
    $error("secm_top: INT_DIV out of range");
  end

  // ==========================================================
  // Registers and address decode
  logic [7:0]  extended_mode_reg;
  logic [5:0]  serial_control_reg;
  logic        frame_err;
  wire         setup   = psel & ~penable;
  wire         access  = psel & penable & pready;
  wire         wr_acc  = access & pwrite;
  wire         rd_acc  = access & ~pwrite;
  // Own index fixes only the extended mode register's address; control, status and data addresses are the same for every instance
  wire [31:0]  ext_addr  = {EXT_INDEX[29:0], 2'b00};
  wire [31:0]  ctrl_addr = {SECM_CTRL_INDEX[29:0], 2'b00};
  wire [31:0]  st_addr   = {SECM_STATUS_INDEX[29:0], 2'b00};
  wire [31:0]  dat_addr  = {SECM_DATA_INDEX[29:0], 2'b00};
  wire         hit_ext   = (paddr == ext_addr);
  wire         hit_ctrl  = (paddr == ctrl_addr);
  wire         hit_st    = (paddr == st_addr);
  wire         hit_dat   = (paddr == dat_addr);
  wire         hit_any   = hit_ext | hit_ctrl | hit_st | hit_dat;

  wire [1:0]   comm_mode           = serial_control_reg[SECM_MODE_LSB +: 2];
  wire [1:0]   cke                 = serial_control_reg[SECM_CKE_LSB +: 2];
  wire         transmit_enable_bit = serial_control_reg[SECM_TE_BIT];
  wire         receive_enable_bit  = serial_control_reg[SECM_RE_BIT];
  wire         mode_async          = (comm_mode == SECM_MODE_ASYNC);
  wire         mode_i2c            = (comm_mode == SECM_MODE_I2C);
  wire         async_clock_source_sel = extended_mode_reg[SECM_ACS_BIT];
  wire         async_base_cycles_sel  = extended_mode_reg[SECM_ASYNC_BASE_CYCLES_SEL_BIT];
  wire         noise_filter_enable    = extended_mode_reg[SECM_NOISE_FILTER_ENABLE_BIT];
  wire         start_detect_edge_sel  = extended_mode_reg[SECM_SDES_BIT];
  wire         ext_unlocked = ~transmit_enable_bit & ~receive_enable_bit;

  // FIFO hookup
  logic [7:0]  shift;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_full;
  secm_rx_e    rx_state;
  wire         fifo_pop = rd_acc & hit_dat;

  // Status view of the live pin levels and buffer
  logic [5:0]  status;
  assign status = {frame_err, fifo_full, fifo_out_valid, sda_internal, scl_internal, rx_internal};

  // Read mux: reserved bits fall out of the mask as zero
  wire [31:0] next_prdata =
    hit_ext  ? {24'h0, extended_mode_reg & SECM_EXT_WMASK} :
    hit_ctrl ? {26'h0, serial_control_reg} :
    hit_st   ? {26'h0, status} :
    hit_dat  ? {24'h0, fifo_out_data} : 32'h0;

  // No wait state: answer registered during setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      prdata  <= setup ? next_prdata : 32'h0;
    end
  end

  // Register writes; the mode fields freeze while the channel runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      extended_mode_reg  <= SECM_EXT_RESET;
      serial_control_reg <= SECM_CTRL_RESET;
    end
    else
    begin
      if (wr_acc && hit_ext && ext_unlocked)
        extended_mode_reg <= pwdata[7:0] & SECM_EXT_WMASK;
      if (wr_acc && hit_ctrl)
        serial_control_reg <= pwdata[5:0];
    end
  end

  // ==========================================================
  // Base clock source
  // Timer source only counts in asynchronous mode with an external clock code
  wire sel_ext_path = mode_async & cke[1];
  wire sel_timer    = sel_ext_path & async_clock_source_sel;
  wire src_level    = sel_timer ? (timer1_compare_out & timer2_compare_out) : ext_clk_in;
  logic       src_prev;
  logic [7:0] div_cnt;
  wire        div_tick  = (div_cnt == 8'(INT_DIV - 1));
  wire        next_tick = sel_ext_path ? (src_level & ~src_prev) : div_tick;

  // Edge detect of the chosen source, or the internal rate divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_prev      <= 1'b0;
      div_cnt       <= 8'h0;
      base_clk_tick <= 1'b0;
    end
    else
    begin
      src_prev      <= src_level;
      div_cnt       <= div_tick ? 8'h0 : div_cnt + 8'h1;
      base_clk_tick <= next_tick;
    end
  end

  // ==========================================================
  // Noise filter: three-sample majority per input lane
  logic [2:0] samp [3];
  logic [2:0] filt;
  wire  [2:0] raw  = {i2c_data_pin, i2c_clock_pin, receive_data_pin};
  wire  [2:0] fen  = {{2{noise_filter_enable & mode_i2c}}, noise_filter_enable & mode_async};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lane
      wire maj = (samp[g][0] & samp[g][1]) | (samp[g][1] & samp[g][2]) | (samp[g][0] & samp[g][2]);
      // Off means the raw pin, with no sample delay added
      assign filt[g] = fen[g] ? maj : raw[g];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          samp[g] <= 3'h7;
        else
          samp[g] <= {samp[g][1:0], raw[g]};
      end
    end
  endgenerate

  // Registered copies for the outside world
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_internal  <= 1'b1;
      scl_internal <= 1'b1;
      sda_internal <= 1'b1;
    end
    else
    begin
      rx_internal  <= filt[0];
      scl_internal <= filt[1];
      sda_internal <= filt[2];
    end
  end

  // ==========================================================
  // Receiver: start detection and bit timing
  logic       rx_prev;
  logic [4:0] cnt;
  logic [2:0] bitn;
  wire        rx_run   = receive_enable_bit & mode_async;
  wire  [4:0] bit_len  = async_base_cycles_sel ? SECM_CYCLES_8 : SECM_CYCLES_16;
  wire  [4:0] last_cnt = bit_len - 5'h1;
  wire  [4:0] half_cnt = {1'b0, bit_len[4:1]} - 5'h1;
  // Edge mode needs a high-to-low step, so a held break never restarts
  wire        start_cond = start_detect_edge_sel ? (rx_prev & ~filt[0]) : ~filt[0];
  wire        bit_end    = base_clk_tick & (cnt == last_cnt);
  wire        frame_done = (rx_state == SECM_RX_STOP) & bit_end;
  wire        ferr_clr   = wr_acc & hit_st & pwdata[SECM_ST_FERR_BIT];

  // Frame state machine; a full FIFO holds the byte and stalls reception
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state       <= SECM_RX_IDLE;
      rx_prev        <= 1'b1;
      cnt            <= 5'h0;
      bitn           <= 3'h0;
      shift          <= 8'h0;
      bit_tick       <= 1'b0;
      start_detected <= 1'b0;
    end
    else
    begin
      rx_prev        <= filt[0];
      bit_tick       <= 1'b0;
      start_detected <= 1'b0;
      if (base_clk_tick && rx_state != SECM_RX_IDLE)
        cnt <= bit_end ? 5'h0 : cnt + 5'h1;
      if (!rx_run)
        rx_state <= SECM_RX_IDLE;
      else
      begin
        case (rx_state)
          SECM_RX_IDLE:
            if (start_cond)
            begin
              rx_state       <= SECM_RX_START;
              cnt            <= 5'h0;
              start_detected <= 1'b1;
            end
          SECM_RX_START:
            if (base_clk_tick && cnt == half_cnt)
            begin
              rx_state <= filt[0] ? SECM_RX_IDLE : SECM_RX_DATA;
              cnt      <= 5'h0;
              bitn     <= 3'h0;
            end
          SECM_RX_DATA:
            if (bit_end)
            begin
              bit_tick <= 1'b1;
              shift    <= {filt[0], shift[7:1]};
              bitn     <= bitn + 3'h1;
              if (bitn == SECM_LAST_BIT)
                rx_state <= SECM_RX_STOP;
            end
          SECM_RX_STOP:
            if (bit_end)
              rx_state <= filt[0] ? SECM_RX_HOLD : SECM_RX_IDLE;
          SECM_RX_HOLD:
            if (fifo_in_ready)
              rx_state <= SECM_RX_IDLE;
          default:
            rx_state <= SECM_RX_IDLE;
        endcase
      end
    end
  end

  // Framing error is sticky; a new error beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_err <= 1'b0;
    else if (frame_done && rx_run && !filt[0])
      frame_err <= 1'b1;
    else if (ferr_clr)
      frame_err <= 1'b0;
  end

  secm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_state == SECM_RX_HOLD),
    .in_ready  (fifo_in_ready),
    .in_data   (shift),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .full      (fifo_full)
  );

  // ==========================================================
  // Checks
  AST_WRITE_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_ext && !ext_unlocked) |=> $stable(extended_mode_reg))
    else $error("extended mode register changed while channel enabled");

  AST_WRITE_TAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_ext && ext_unlocked) |=> extended_mode_reg == ($past(pwdata[7:0]) & 8'hb1))
    else $error("extended mode write not taken while idle");

  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_ext) |-> (prdata[31:7] == 25'h0 || prdata[31:8] == 24'h0) && prdata[6] == 1'b0
      && prdata[3:1] == 3'h0)
    else $error("reserved extended mode bits read non-zero");

  AST_TIMER_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_async && cke[1] && async_clock_source_sel && timer1_compare_out && timer2_compare_out && !src_prev)
      |=> base_clk_tick)
    else $error("timer compare AND did not clock the base tick");

  AST_SRC_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    (!(mode_async && cke[1]) && !div_tick) |=> !base_clk_tick)
    else $error("external source leaked outside asynchronous external clock mode");

  AST_FILTER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !noise_filter_enable |=> rx_internal == $past(receive_data_pin) && sda_internal == $past(i2c_data_pin)
      && scl_internal == $past(i2c_clock_pin))
    else $error("unfiltered input not passed straight through");

  AST_FILTER_RX: assert property (@(posedge pclk) disable iff (!presetn)
    (noise_filter_enable && mode_async && samp[0][1] && samp[0][0]) |=> rx_internal)
    else $error("receive filter let a single low glitch through");

  AST_FILTER_I2C: assert property (@(posedge pclk) disable iff (!presetn)
    (noise_filter_enable && mode_i2c && !samp[1][1] && !samp[1][0] && !samp[2][1] && !samp[2][0])
      |=> !scl_internal && !sda_internal)
    else $error("I2C filter did not follow two low samples");

  AST_START_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == SECM_RX_IDLE && rx_run && !start_detect_edge_sel && !filt[0]) |=> start_detected)
    else $error("low level did not start reception");

  AST_START_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == SECM_RX_IDLE && rx_run && start_detect_edge_sel && !rx_prev) |=> !start_detected)
    else $error("edge mode started without a falling edge");

  AST_BIT_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == SECM_RX_DATA && rx_run && base_clk_tick && cnt == (async_base_cycles_sel ? 5'h07 : 5'h0f))
      |=> bit_tick)
    else $error("bit period length does not match base cycles selection");

  COV_TIMER_TICK: cover property (@(posedge pclk) disable iff (!presetn) sel_timer ##1 base_clk_tick);
  COV_EDGE_START: cover property (@(posedge pclk) disable iff (!presetn) start_detect_edge_sel && start_detected);
  COV_FRAME_PUSH: cover property (@(posedge pclk) disable iff (!presetn) rx_state == SECM_RX_HOLD && fifo_in_ready);
  COV_FIFO_FULL:  cover property (@(posedge pclk) disable iff (!presetn) fifo_full);

endmodule // secm_top
